/* sync_baud_gen.sv */
// baud-rate generator for the synchronous serial port, axi4-lite slave
// assumes clock inputs are levels synchronous to sys_clk_in
// Functional notes
// - setting enable bit starts the counter and baud output
// - clearing enable stops the generator and zeroes the count
// - control bits 6..0 are the reload value of the counter
// - output frequency is input clock over twice reload plus two
// - status bit 7 reads one while enabled, zero while disabled
// - status read returns live count in bits 6..0
// - source bit set picks internal serial clock, clear prescaled
`timescale 1ns/100ps
`default_nettype none
module sync_baud_gen (
   input  wire logic                        sys_clk_in,
   input  wire logic                        reset_n_in,
   input  wire logic                        internal_serial_clock_in,
   input  wire logic                        prescaled_clock_in,
   input  wire logic [sync_baud_pkg::ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic                        s_axi_awvalid_in,
   output var  logic                        s_axi_awready_out,
   input  wire logic [sync_baud_pkg::DATA_W-1:0] s_axi_wdata_in,
   input  wire logic [3:0]                  s_axi_wstrb_in,
   input  wire logic                        s_axi_wvalid_in,
   output var  logic                        s_axi_wready_out,
   output var  logic [1:0]                  s_axi_bresp_out,
   output var  logic                        s_axi_bvalid_out,
   input  wire logic                        s_axi_bready_in,
   input  wire logic [sync_baud_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic                        s_axi_arvalid_in,
   output var  logic                        s_axi_arready_out,
   output var  logic [sync_baud_pkg::DATA_W-1:0] s_axi_rdata_out,
   output var  logic [1:0]                  s_axi_rresp_out,
   output var  logic                        s_axi_rvalid_out,
   input  wire logic                        s_axi_rready_in,
   output var  logic                        baud_clk_out
);
   import sync_baud_pkg::*;

   // write channel state
   logic              aw_have_q, aw_have_d;
   logic              w_have_q, w_have_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [7:0]        wdata_q, wdata_d;
   logic              wstrb0_q, wstrb0_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   // read channel state
   logic              rvalid_q, rvalid_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [1:0]        rresp_q, rresp_d;
   // registers
   logic [7:0]        control_q, control_d;
   logic              source_q, source_d;
   logic              gen_input_clock_q, gen_input_clock_d;
   logic              baud_q, baud_d;
   // bus ready outputs, registered
   logic              awready_q, awready_d;
   logic              wready_q, wready_d;
   logic              arready_q, arready_d;

   logic             tick;
   logic [CNT_W-1:0] count_now;
   logic             tog;
   logic             gen_enable_bit;
   logic             do_write;

   assign gen_enable_bit = control_q[ENABLE_BIT];
   assign do_write = aw_have_q && w_have_q && !bvalid_q;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb0_d  = wstrb0_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      control_d = control_q;
      source_d  = source_q;
      if (s_axi_awvalid_in && !aw_have_q) begin
         aw_have_d = 1'b1;
         awaddr_d  = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_have_q) begin
         w_have_d = 1'b1;
         wdata_d  = s_axi_wdata_in[7:0];
         wstrb0_d = s_axi_wstrb_in[0];
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = RESP_OKAY;
         if (addr_hit(awaddr_q, CONTROL_IDX)) begin
            if (wstrb0_q) begin
               control_d = wdata_q;
            end
         end else if (addr_hit(awaddr_q, SOURCE_IDX)) begin
            if (wstrb0_q) begin
               source_d = wdata_q[SOURCE_BIT];
            end
         end else if (!addr_hit(awaddr_q, COUNT_STATUS_IDX)) begin
            bresp_d = RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready_in) begin
         bvalid_d = 1'b0;
      end
      awready_d = !aw_have_d;
      wready_d  = !w_have_d;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 8'h00;
         wstrb0_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         control_q <= CONTROL_RESET;
         source_q  <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb0_q  <= wstrb0_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         control_q <= control_d;
         source_q  <= source_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
      end
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_arvalid_in && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         rdata_d  = '0;
         if (addr_hit(s_axi_araddr_in, COUNT_STATUS_IDX)) begin
            rdata_d[ENABLE_BIT]  = gen_enable_bit;
            rdata_d[CNT_W-1:0]   = count_now;
         end else if (addr_hit(s_axi_araddr_in, SOURCE_IDX)) begin
            rdata_d[SOURCE_BIT] = source_q;
         end else if (!addr_hit(s_axi_araddr_in, CONTROL_IDX)) begin
            rresp_d = RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready_in) begin
         rvalid_d = 1'b0;
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
         arready_q <= 1'b1;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
         arready_q <= arready_d;
      end
   end

   // source mux, registered so the edge detector sees a clean level
   always_comb begin
      gen_input_clock_d = source_q ? internal_serial_clock_in
                                   : prescaled_clock_in;
      baud_d = tog;
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gen_input_clock_q <= 1'b0;
         baud_q            <= 1'b0;
      end else begin
         gen_input_clock_q <= gen_input_clock_d;
         baud_q            <= baud_d;
      end
   end

   sync_baud_edge sync_baud_edge_i (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .level_in   (gen_input_clock_q),
      .rise_out   (tick)
   );

   // half period is reload+1 input clocks: f = fin / (2*reload+2)
   sync_baud_counter sync_baud_counter_i (
      .sys_clk_in      (sys_clk_in),
      .reset_n_in      (reset_n_in),
      .enable_in       (gen_enable_bit),
      .tick_in         (tick),
      .reload_value_in (control_q[CNT_W-1:0]),
      .count_now_out   (count_now),
      .baud_clk_out    (tog)
   );

   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out  = wready_q;
   assign s_axi_bvalid_out  = bvalid_q;
   assign s_axi_bresp_out   = bresp_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rvalid_out  = rvalid_q;
   assign s_axi_rdata_out   = rdata_q;
   assign s_axi_rresp_out   = rresp_q;
   assign baud_clk_out      = baud_q;
endmodule
`default_nettype wire

/* sync_baud_pkg.sv */
// constants for the synchronous serial baud-rate generator
// assumes a 32-bit axi4-lite register bus
package sync_baud_pkg;
   // register indices; byte address is four times the index
   localparam int unsigned ADDR_W            = 18;
   localparam int unsigned IDX_LSB           = 2;
   localparam int unsigned DATA_W            = 32;
   localparam int unsigned CNT_W             = 7;
   localparam logic [15:0] COUNT_STATUS_IDX  = 16'hf48a;
   // control and source indices: free words two indices either side of the status word
   localparam logic [15:0] CONTROL_IDX       = 16'hf488;
   localparam logic [15:0] SOURCE_IDX        = 16'hf48c;
   localparam int unsigned ENABLE_BIT        = 7;
   localparam int unsigned SOURCE_BIT        = 2;
   localparam logic [6:0]  CNT_RESET         = 7'h00;
   localparam logic [7:0]  CONTROL_RESET     = 8'h00;
   localparam logic [1:0]  RESP_OKAY         = 2'b00;
   localparam logic [1:0]  RESP_SLVERR       = 2'b10;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [15:0]       reg_idx);
      return a[ADDR_W-1:IDX_LSB] == reg_idx;
   endfunction
endpackage

/* sync_baud_edge.sv */
// rising-edge detector for the selected generator input clock
// assumes the input level is synchronous to sys_clk_in
`timescale 1ns/100ps
`default_nettype none
module sync_baud_edge (
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic level_in,
   output var  logic rise_out
);
   logic level_q;
   logic level_d;
   always_comb begin
      level_d = level_in;
   end
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level_d;
      end
   end
   assign rise_out = level_in & ~level_q;
endmodule
`default_nettype wire

/* sync_baud_counter.sv */
// seven-bit reloading down counter with square output toggle
// assumes tick_in is a one-cycle pulse per generator input clock
`timescale 1ns/100ps
`default_nettype none
module sync_baud_counter
   import sync_baud_pkg::*;
(
   input  wire logic             sys_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             enable_in,
   input  wire logic             tick_in,
   input  wire logic [CNT_W-1:0] reload_value_in,
   output var  logic [CNT_W-1:0] count_now_out,
   output var  logic             baud_clk_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic             tog_q;
   logic             tog_d;
   always_comb begin
      cnt_d = cnt_q;
      tog_d = tog_q;
      if (!enable_in) begin
         cnt_d = CNT_RESET;
         tog_d = 1'b0;
      end else if (tick_in) begin
         if (cnt_q == CNT_RESET) begin
            cnt_d = reload_value_in;
            tog_d = ~tog_q;
         end else begin
            cnt_d = cnt_q - 7'h01;
         end
      end
   end
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= CNT_RESET;
         tog_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tog_q <= tog_d;
      end
   end
   assign count_now_out = cnt_q;
   assign baud_clk_out  = tog_q;
endmodule
`default_nettype wire

/* sync_baud_gen_props.sv */
// port checker for the baud-rate generator
// assumes it is bound to sync_baud_gen
`timescale 1ns/100ps
`default_nettype none
module sync_baud_gen_props (
   input wire logic        sys_clk_in,
   input wire logic        reset_n_in,
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_wready_out,
   input wire logic [1:0]  s_axi_bresp_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic [sync_baud_pkg::ADDR_W-1:0] s_axi_araddr_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in
);
   import sync_baud_pkg::*;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   logic st_q;
   // last read went to the count/status word
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_q <= 1'b0;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         st_q <= s_axi_araddr_in[ADDR_W-1:IDX_LSB] == COUNT_STATUS_IDX;
      end
   end
   sequence s_w_both;
      s_axi_awvalid_in && s_axi_awready_out &&
      s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   a_w_answer: assert property (s_w_both |-> ##[1:3] s_axi_bvalid_out)
      else $error("write not answered");
   a_aw_held: assert property (s_axi_awvalid_in && s_axi_awready_out
      |=> !s_axi_awready_out)
      else $error("awready not dropped");
   a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped");
   a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out)
      else $error("read not answered");
   a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped");
   a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("arready high during read");
   a_r_upper: assert property (s_axi_rvalid_out
      |-> s_axi_rdata_out[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_off_zero: assert property (s_axi_rvalid_out && st_q &&
      !s_axi_rdata_out[7] |-> s_axi_rdata_out[6:0] == 7'h00)
      else $error("count not zero while stopped");
endmodule
bind sync_baud_gen sync_baud_gen_props sync_baud_gen_props_i (
   .sys_clk_in, .reset_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
   .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
   .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
   .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
   .s_axi_rvalid_out, .s_axi_rready_in);
`default_nettype wire

/* test_sync_baud_gen.sv */
// self-checking bench for the baud-rate generator
// assumes the bench drives every register over axi4-lite
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
   err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_sync_baud_gen;
   import sync_baud_pkg::*;
   // byte addresses: four times the register index
   localparam logic [ADDR_W-1:0] COUNT_STATUS_ADDR = {COUNT_STATUS_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] CONTROL_ADDR      = {CONTROL_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] SOURCE_ADDR       = {SOURCE_IDX, 2'b00};
   localparam logic [ADDR_W-1:0] UNMAPPED_ADDR     = {16'hf490, 2'b00};
   logic        clk = 1'b0, reset_n = 1'b0, ser = 1'b0, pre = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [ADDR_W-1:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rd, d;
   logic        awr, wr_rdy, bv, arr, rv, baud;
   logic [1:0]  br, rr, r;
   int          err_total = 0, checked = 0, pc = 0;
   always #10 clk = ~clk;
   // internal clock period 2 cycles, prescaled period 6
   always @(posedge clk) begin
      ser <= ~ser;
      pc <= (pc == 2) ? 0 : pc + 1;
      if (pc == 2) pre <= ~pre;
   end
   sync_baud_gen sync_baud_gen_i (.sys_clk_in(clk), .reset_n_in(reset_n),
      .internal_serial_clock_in(ser), .prescaled_clock_in(pre),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(br),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
      .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rre), .baud_clk_out(baud));
   task conclude;
      if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task tmo;
      err_total++;
      conclude;
   endtask
   task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
         if (bv) break;
      end
      if (n == 50) tmo;
      r = br;
      bre <= 1'b0;
   endtask
   task rdr(input logic [ADDR_W-1:0] a);
      int n;
      @(posedge clk);
      ara <= a; arv <= 1'b1; rre <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      if (n == 50) tmo;
      d = rd; r = rr;
      rre <= 1'b0;
   endtask
   // waits for the baud output to reach level v, counting cycles
   task wlev(input logic v, inout int n);
      while (baud !== v) begin
         @(posedge clk);
         n++;
         if (n > 1200) tmo;
      end
   endtask
   task per(input int e);
      int n;
      n = 0; wlev(1'b0, n); wlev(1'b1, n);
      n = 0; wlev(1'b0, n); wlev(1'b1, n);
      `CHK("period", e, n)
   endtask
   task t_reset;
      rdr(COUNT_STATUS_ADDR);
      `CHK("status", 32'h00000000, d)
      `CHK("resp", RESP_OKAY, r)
      rdr(SOURCE_ADDR);
      `CHK("source", 32'h00000000, d)
      `CHK("idle baud", 1'b0, baud)
   endtask
   task t_unmapped;
      wr(UNMAPPED_ADDR, 32'h000000ff);
      `CHK("bad wr", RESP_SLVERR, r)
      rdr(UNMAPPED_ADDR);
      `CHK("bad rd", RESP_SLVERR, r)
   endtask
   task t_rates;
      logic       s [3] = '{1'b0, 1'b0, 1'b1};
      logic [6:0] v [3] = '{7'h00, 7'h03, 7'h7f};
      int         e [3] = '{12, 48, 512};
      for (int i = 0; i < 3; i++) begin
         wr(SOURCE_ADDR, {29'h0, s[i], 2'b00});
         wr(CONTROL_ADDR, {24'h0, 1'b1, v[i]});
         per(e[i]);
         rdr(COUNT_STATUS_ADDR);
         `CHK("running", 1'b1, d[7])
         `CHK("count range", 1'b1, d[6:0] <= v[i])
         rdr(SOURCE_ADDR);
         `CHK("source bit", s[i], d[2])
      end
   endtask
   task t_disable;
      wr(CONTROL_ADDR, 32'h0000007f);
      repeat (4) @(posedge clk);
      rdr(COUNT_STATUS_ADDR);
      `CHK("stopped", 32'h00000000, d)
      `CHK("stopped baud", 1'b0, baud)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      t_reset;
      t_unmapped;
      t_rates;
      t_disable;
      conclude;
   end
endmodule
`default_nettype wire
